/* File: inc/dpr_pkg.sv */
// package: constants and types for the data parity report block
`default_nettype none
package dpr_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] MASK_OFF = 8'h08;
    localparam logic [7:0] STATE_OFF = 8'h0c;
    // control field positions
    localparam int PRI_RESP_BIT = 0;
    localparam int SEC_RESP_BIT = 1;
    // status / mask field positions
    localparam int PRI_DPD_BIT = 0;
    localparam int SEC_DPD_BIT = 1;
    localparam int PERR_EVT_BIT = 2;
    localparam int STAT_W = 3;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    // perr output hold time in clocks after an error event
    localparam logic [1:0] PERR_HOLD = 2'h1;

    typedef enum logic [1:0]
    {
        XT_READ = 2'h0,
        XT_POSTED = 2'h1,
        XT_DELAYED = 2'h2
    } xact_t;

    typedef struct packed
    {
        logic valid;
        xact_t kind;
        logic upstream;
        logic err_on_sec;
    } parity_evt_t;

    typedef struct packed
    {
        logic pri_resp;
        logic sec_resp;
    } resp_en_t;
endpackage
`default_nettype wire

/* File: rtl/dpr_classify.sv */
// combinational classification of one parity event into reporting actions
`default_nettype none
module dpr_classify
(
    input wire dpr_pkg::parity_evt_t evt,
    input wire dpr_pkg::resp_en_t en,
    input wire logic pri_master,
    input wire logic sec_master,
    input wire logic dw_completion_perr,
    output logic set_pri_dpd,
    output logic set_sec_dpd,
    output logic drive_perr
);
    wire logic on_pri = evt.valid && !evt.err_on_sec;
    wire logic on_sec = evt.valid && evt.err_on_sec;
    wire logic up = evt.upstream;
    wire logic wr_type = (evt.kind == dpr_pkg::XT_POSTED) || (evt.kind == dpr_pkg::XT_DELAYED);
    wire logic any_type = wr_type || (evt.kind == dpr_pkg::XT_READ);
    // primary bit: upstream traffic mastered on primary, error seen there
    assign set_pri_dpd = on_pri && up && any_type && pri_master && en.pri_resp;
    // secondary bit: downstream traffic mastered on secondary
    assign set_sec_dpd = on_sec && !up && any_type && sec_master && en.sec_resp;
    // perr: upstream read as initiator, downstream write as target
    wire logic pri_case = on_pri && en.pri_resp &&
        ((up && evt.kind == dpr_pkg::XT_READ) || (!up && wr_type));
    wire logic dw_case = on_sec && !up && (evt.kind == dpr_pkg::XT_DELAYED) &&
        dw_completion_perr && en.pri_resp && en.sec_resp;
    assign drive_perr = pri_case || dw_case;
endmodule
`default_nettype wire

/* File: rtl/dpr_sticky.sv */
// sticky status bits: hardware set wins over write-one-to-clear
`default_nettype none
module dpr_sticky
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [2:0] set_bits,
    input wire logic [2:0] clr_bits,
    output logic [2:0] bits_ff
);
    wire logic [2:0] nxt_bits = (bits_ff & ~clr_bits) | set_bits;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            bits_ff <= 3'h0;
        else
            bits_ff <= nxt_bits;
    end
endmodule
`default_nettype wire

/* File: rtl/dpr_top.sv */
// data parity detected status and primary parity error output of a bridge
// How it works
// - primary bit only when mastering primary bus
// - primary bit needs primary response enable
// - primary trigger: target perr or own mismatch
// - primary bit only for upstream, error primary
// - secondary bit only when mastering secondary bus
// - secondary bit needs secondary response enable
// - secondary trigger: target perr or own mismatch
// - secondary bit only for downstream, error secondary
// - drive perr only as write target/read initiator
// - perr for primary errors, upstream read, downstream writes
// - perr on delayed write completion, both enables
// - perr high in every other case
`default_nettype none
module dpr_top
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic evt_valid,
    input wire logic [1:0] evt_kind,
    input wire logic evt_upstream,
    input wire logic evt_err_on_sec,
    input wire logic pri_master,
    input wire logic sec_master,
    input wire logic pri_perr_in_n,
    input wire logic pri_mismatch,
    input wire logic sec_perr_in_n,
    input wire logic sec_mismatch,
    input wire logic dw_completion_perr,
    output logic pri_perr_n,
    output logic pri_perr_oe,
    output logic irq
);
    logic [1:0] ctrl_ff;
    logic [2:0] mask_ff;
    logic [2:0] status;
    logic [31:0] rdata_ff;
    logic perr_n_ff;
    logic perr_oe_ff;
    logic irq_ff;
    logic set_pri;
    logic set_sec;
    logic drive;

    dpr_pkg::resp_en_t en;
    dpr_pkg::parity_evt_t evt;
    assign en.pri_resp = ctrl_ff[dpr_pkg::PRI_RESP_BIT];
    assign en.sec_resp = ctrl_ff[dpr_pkg::SEC_RESP_BIT];
    // trigger is either the target's perr or our own parity check
    wire logic pri_trig = !pri_perr_in_n || pri_mismatch;
    wire logic sec_trig = !sec_perr_in_n || sec_mismatch;
    wire logic trig = evt_err_on_sec ? sec_trig : pri_trig;
    assign evt.valid = evt_valid && trig;
    assign evt.kind = dpr_pkg::xact_t'(evt_kind);
    assign evt.upstream = evt_upstream;
    assign evt.err_on_sec = evt_err_on_sec;

    dpr_classify u_cls
    (
        .evt(evt),
        .en(en),
        .pri_master(pri_master),
        .sec_master(sec_master),
        .dw_completion_perr(dw_completion_perr),
        .set_pri_dpd(set_pri),
        .set_sec_dpd(set_sec),
        .drive_perr(drive)
    );

    wire logic wr_ctrl = wr && addr == dpr_pkg::CTRL_OFF;
    wire logic wr_stat = wr && addr == dpr_pkg::STATUS_OFF;
    wire logic wr_mask = wr && addr == dpr_pkg::MASK_OFF;
    wire logic [2:0] set_bits = {drive, set_sec, set_pri};
    wire logic [2:0] clr_bits = wr_stat ? wdata[2:0] : 3'h0;

    dpr_sticky u_sticky
    (
        .core_clk(core_clk),
        .rst(rst),
        .set_bits(set_bits),
        .clr_bits(clr_bits),
        .bits_ff(status)
    );

    wire logic [31:0] rd_mux =
        (addr == dpr_pkg::CTRL_OFF) ? {30'h0, ctrl_ff} :
        (addr == dpr_pkg::STATUS_OFF) ? {29'h0, status} :
        (addr == dpr_pkg::MASK_OFF) ? {29'h0, mask_ff} :
        (addr == dpr_pkg::STATE_OFF) ? {29'h0, pri_master, sec_master, perr_oe_ff} :
        dpr_pkg::RD_UNMAPPED;
    // the irq follows the next sticky state, so a bit set this cycle shows in irq with the status bit
    wire logic [2:0] nxt_status = (status & ~clr_bits) | set_bits;
    // the next mask is used too, so a mask write never leaves a stale irq cycle
    wire logic [2:0] nxt_mask = wr_mask ? wdata[2:0] : mask_ff;
    wire logic nxt_irq = |(nxt_status & nxt_mask);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_ff <= dpr_pkg::CTRL_RST;
            mask_ff <= dpr_pkg::MASK_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= wdata[1:0];
            if (wr_mask)
                mask_ff <= wdata[2:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rdata_ff <= 32'h0000_0000;
        else
            rdata_ff <= rd ? rd_mux : 32'h0000_0000;
    end

    // perr is driven low the cycle after the event, otherwise released high
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            perr_n_ff <= 1'b1;
            perr_oe_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            perr_n_ff <= !drive;
            perr_oe_ff <= drive;
            irq_ff <= nxt_irq;
        end
    end

    assign rdata = rdata_ff;
    assign pri_perr_n = perr_n_ff;
    assign pri_perr_oe = perr_oe_ff;
    assign irq = irq_ff;
endmodule
`default_nettype wire

/* File: dv/dpr_top_monitor.sv */
// checker: port-level properties of the parity report block
`default_nettype none
module dpr_top_monitor
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wr,
    input wire logic evt_valid,
    input wire logic [1:0] evt_kind,
    input wire logic evt_upstream,
    input wire logic evt_err_on_sec,
    input wire logic pri_perr_in_n,
    input wire logic pri_mismatch,
    input wire logic dw_completion_perr,
    input wire logic pri_perr_n,
    input wire logic pri_perr_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_quiet;
        !evt_valid ##1 !evt_valid;
    endsequence
    sequence s_sec_err;
        evt_valid && evt_err_on_sec && !dw_completion_perr;
    endsequence
    property p_quiet; s_quiet |=> pri_perr_n && !pri_perr_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("perr without event");
    property p_oe; pri_perr_oe == !pri_perr_n; endproperty
    a_oe: assert property (p_oe) else $error("enable and perr disagree");
    property p_cause; !pri_perr_n |-> $past(evt_valid); endproperty
    a_cause: assert property (p_cause) else $error("perr with no event");
    property p_sec_only; s_sec_err |=> pri_perr_n; endproperty
    a_sec_only: assert property (p_sec_only) else $error("perr on secondary");
    property p_up_wr; evt_valid && evt_upstream && evt_kind != 2'h0 |=> pri_perr_n; endproperty
    a_up_wr: assert property (p_up_wr) else $error("perr on upstream write");
    property p_dn_rd; evt_valid && !evt_upstream && evt_kind == 2'h0 |=> pri_perr_n; endproperty
    a_dn_rd: assert property (p_dn_rd) else $error("perr on downstream read");
    property p_no_trig;
        evt_valid && !evt_err_on_sec && pri_perr_in_n && !pri_mismatch |=> pri_perr_n;
    endproperty
    a_no_trig: assert property (p_no_trig) else $error("perr with no trigger");
    // only a write can clear or mask, so irq never drops on its own
    property p_hold; irq && !wr |=> irq; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped");
endmodule
bind dpr_top dpr_top_monitor u_mon (.*);
`default_nettype wire

/* File: dv/pci_agent.sv */
// far-side bus agent driving the target parity error lines
`default_nettype none
module pci_agent
(
    input wire logic [1:0] perr_req,
    output logic pri_perr_in_n,
    output logic sec_perr_in_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // released lines return to the pull-up level
    assign pri_perr_in_n = !perr_req[0];
    assign sec_perr_in_n = !perr_req[1];
endmodule
`default_nettype wire

/* File: dv/dpr_top_test.sv */
// self-checking bench of the data parity report block
`default_nettype none
`define chk(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module dpr_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, evt_valid = 1'b0;
    logic evt_upstream = 1'b0, evt_err_on_sec = 1'b0, pri_master = 1'b0, sec_master = 1'b0;
    logic pri_mismatch = 1'b0, sec_mismatch = 1'b0, dw_completion_perr = 1'b0;
    logic [1:0] evt_kind = 2'h3, perr_req = 2'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic pri_perr_in_n, sec_perr_in_n, pri_perr_n, pri_perr_oe, irq;
    int err_total = 0, comparisons = 0;
    // row: quiet, kind[2], up, sec, line, en{sec,pri}, dpd{sec,pri}, perr_n
    logic [10:0] rows [14] = '{11'h08a, 11'h081, 11'h1bb, 11'h28b, 11'h075, 11'h155,
        11'h27c, 11'h275, 11'h108, 11'h228, 11'h019, 11'h0f9, 11'h169, 11'h499};
    always #10 core_clk = ~core_clk;
    dpr_top DUT (.*);
    pci_agent u_agent (.perr_req(perr_req), .pri_perr_in_n(pri_perr_in_n),
        .sec_perr_in_n(sec_perr_in_n));
    task wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // swap hands mastership to the other bus, which must block both dpd bits
    task ev(input logic [10:0] r, input logic swap = 1'b0);
        @(posedge core_clk);
        evt_valid <= 1'b1;
        {evt_kind, evt_upstream, evt_err_on_sec} <= r[9:6];
        pri_master <= r[7] ^ swap;
        sec_master <= !r[7] ^ swap;
        pri_mismatch <= !r[5] && !r[6] && !r[10];
        sec_mismatch <= !r[5] && r[6] && !r[10];
        perr_req <= {r[5] && r[6], r[5] && !r[6]};
        dw_completion_perr <= r[9:5] == 5'h13;
        @(posedge core_clk);
        {evt_valid, pri_mismatch, sec_mismatch, dw_completion_perr} <= 4'h0;
        perr_req <= 2'h0;
        #1 `chk(pri_perr_n, r[0])
        `chk(pri_perr_oe, !r[0])
    endtask
    task conclude;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        // every register and one unmapped place read zero after reset
        for (int i = 0; i < 5; i++)
        begin
            rd_reg(8'(i * 4));
            `chk(d, 32'h0)
        end
        foreach (rows[i])
        begin
            wr_reg(dpr_pkg::CTRL_OFF, {30'h0, rows[i][4:3]});
            wr_reg(dpr_pkg::STATUS_OFF, 32'h7);
            ev(rows[i]);
            rd_reg(dpr_pkg::STATUS_OFF);
            `chk(d, {29'h0, ~rows[i][0], rows[i][2:1]})
        end
        // dpd bits need the bridge to master the bus, perr does not
        wr_reg(dpr_pkg::CTRL_OFF, 32'h3);
        wr_reg(dpr_pkg::STATUS_OFF, 32'h7);
        ev(rows[0], 1'b1);
        ev(rows[4], 1'b1);
        rd_reg(dpr_pkg::STATUS_OFF);
        `chk(d, 32'h4)
        wr_reg(dpr_pkg::MASK_OFF, 32'h7);
        ev(rows[0]);
        rd_reg(dpr_pkg::STATUS_OFF);
        `chk(d, 32'h5)
        `chk(irq, 1'b1)
        rd_reg(dpr_pkg::STATE_OFF);
        `chk(d, 32'h4)
        wr_reg(8'h14, 32'h7);
        wr_reg(dpr_pkg::STATUS_OFF, 32'h1);
        rd_reg(dpr_pkg::STATUS_OFF);
        `chk(d, 32'h4)
        wr_reg(dpr_pkg::MASK_OFF, 32'h3);
        rd_reg(dpr_pkg::MASK_OFF);
        `chk(d, 32'h3)
        `chk(irq, 1'b0)
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        rd_reg(dpr_pkg::STATUS_OFF);
        `chk(d, 32'h0)
        conclude();
    end
endmodule
`default_nettype wire
